// *** rtl/ises_core.sv ***
// ises_core: two-wire bus slave event sequencer with simple master start,
// wait control, arbitration loss detection, status snapshot and interrupt.
// assumes open-drain pads outside; APB master on core_clk.
// Overview of operation
// - as slave transmitter keep sending bytes while the master acks and end on a missing ack.
// - as slave receiver withhold ack when software clears ack enable; master then stops or restarts.
// - after a data byte event, except the one ending a transmit on a missing ack, hold the clock line low until software releases the wait.
// - raise the event interrupt on stop only while the stop interrupt enable is set.
// - on an extension code take part in the exchange whatever the own address is.
// - on arbitration loss in the address byte drop master status and carry on as slave.
// - detect loss caused by a repeated start inside a data byte and raise an event.
// - on each event capture master, loss, extension, match, direction, ack, start and stop.
// - keep one direction status and drive the direction output straight from it.
`timescale 1ns/1ns
module ises_core
  import ises_pkg::*;
(
  input wire logic core_clk, // core clock
  input wire logic rst_n, // async reset, active low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic sclIn, // clock pin level
  output logic sclOut, // clock pin drive value
  output logic sclOe_n, // clock pin enable, low drives
  input wire logic sdaIn, // data pin level
  output logic sdaOut, // data pin drive value
  output logic sdaOe_n, // data pin enable, low drives
  output logic transmitDirection, // device is transmitting
  output logic busEventIrq // bus event interrupt level
);
  import ises_pkg::*;

  typedef struct packed {
    ises_phase_t phase;
    logic sclP;
    logic sdaP;
    logic busy;
    logic [3:0] bitCnt;
    logic [7:0] shift;
    logic [7:0] txByte;
    logic [7:0] rxData;
    logic hold;
    logic ackDrive;
    logic sdaRel;
    logic sclRel;
    logic trc;
    logic master;
    logic mstPend;
    logic mstGen;
    logic mstSclLow;
    logic [9:0] mstCnt;
    logic arbLost;
    logic extCode;
    logic addrMatch;
    logic ackDet;
    logic startDet;
    logic stopDet;
    logic [7:0] snap;
    logic [ISES_EVW-1:0] irqStat;
    logic [ISES_EVW-1:0] irqMask;
    logic [3:0] ctrl;
    logic [6:0] ownAddr;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic irq;
  } ises_state_t;

  ises_state_t s_r;
  ises_state_t s_nxt;
  logic sclS;
  logic sdaS;

  // pin synchronisers
  ises_sync u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .sclIn(sclIn),
    .sdaIn(sdaIn),
    .sclSync(sclS),
    .sdaSync(sdaS)
  );

  // register select, shared by read and write paths
  function automatic logic [6:0] regSel(input logic [7:0] a);
    logic [6:0] r;
    r = 7'h00;
    if (a == ISES_OFS_CTRL)
      r[0] = 1'b1;
    else if (a == ISES_OFS_ADDR)
      r[1] = 1'b1;
    else if (a == ISES_OFS_DATA)
      r[2] = 1'b1;
    else if (a == ISES_OFS_SNAP)
      r[3] = 1'b1;
    else if (a == ISES_OFS_ISTAT)
      r[4] = 1'b1;
    else if (a == ISES_OFS_IMASK)
      r[5] = 1'b1;
    else
      r[6] = 1'b1;
    return r;
  endfunction

  logic sclRise;
  logic sclFall;
  logic startSeen;
  logic stopSeen;
  logic acc;
  logic wr;
  logic rd;
  logic [6:0] sel;
  logic [ISES_EVW-1:0] ev;
  logic matchNow;
  logic extNow;
  logic [7:0] byteNow;
  logic txBit;

  // bus edge and condition detection on synchronised levels
  always_comb
  begin
    sclRise = sclS & ~s_r.sclP;
    sclFall = ~sclS & s_r.sclP;
    startSeen = sclS & s_r.sclP & s_r.sdaP & ~sdaS;
    stopSeen = sclS & s_r.sclP & ~s_r.sdaP & sdaS;
    byteNow = {s_r.shift[6:0], sdaS};
    extNow = byteNow[7:4] == ISES_EXT_PREFIX;
    matchNow = byteNow[7:1] == s_r.ownAddr;
    sel = regSel(paddr);
    acc = psel & penable & s_r.ready;
    wr = acc & pwrite;
    rd = acc & ~pwrite;
  end

  // whole next state
  always_comb
  begin
    s_nxt = s_r;
    ev = '0;
    txBit = 1'b0;
    s_nxt.sclP = sclS;
    s_nxt.sdaP = sdaS;

    // apb: one wait state, then answer
    s_nxt.ready = psel & penable & ~s_r.ready;
    s_nxt.err = 1'b0;
    if (psel & penable & ~s_r.ready)
    begin
      s_nxt.err = sel[6];
      s_nxt.rdata = '0;
      if (sel[0])
        s_nxt.rdata[3:0] = s_r.ctrl;
      else if (sel[1])
        s_nxt.rdata[6:0] = s_r.ownAddr;
      else if (sel[2])
        s_nxt.rdata[7:0] = s_r.rxData;
      else if (sel[3])
        s_nxt.rdata[7:0] = s_r.snap;
      else if (sel[4])
        s_nxt.rdata[ISES_EVW-1:0] = s_r.irqStat;
      else if (sel[5])
        s_nxt.rdata[ISES_EVW-1:0] = s_r.irqMask;
    end

    // register writes and command pulses
    if (wr & sel[0])
    begin
      s_nxt.ctrl = pwdata[3:0];
      if (pwdata[ISES_CB_WREL])
        s_nxt.hold = 1'b0;
      if (pwdata[ISES_CB_START] & pwdata[ISES_CB_EN])
        s_nxt.mstPend = 1'b1;
      if (pwdata[ISES_CB_LEAVE])
      begin
        s_nxt.phase = ISES_PH_DROP;
        s_nxt.hold = 1'b0;
        s_nxt.master = 1'b0;
        s_nxt.mstSclLow = 1'b0;
        s_nxt.trc = 1'b0;
        s_nxt.ackDrive = 1'b0;
      end
    end
    if (wr & sel[1])
      s_nxt.ownAddr = pwdata[6:0];
    if (wr & sel[2])
    begin
      s_nxt.txByte = pwdata[7:0];
      s_nxt.hold = 1'b0;
      if (s_r.bitCnt == '0)
        s_nxt.shift = pwdata[7:0];
    end
    if (wr & sel[5])
      s_nxt.irqMask = pwdata[ISES_EVW-1:0];

    // master start generation once the bus is free
    if (s_r.mstPend & ~s_r.busy & ~s_r.mstGen)
    begin
      s_nxt.mstGen = 1'b1;
      s_nxt.shift = s_r.txByte;
    end

    // bit counting and shifting on clock edges
    if (sclRise & s_r.busy)
    begin
      s_nxt.bitCnt = 4'(s_r.bitCnt + 4'h1);
      if (s_r.bitCnt < ISES_BIT_LAST)
      begin
        s_nxt.shift = byteNow;
        if (s_r.master & s_r.trc & s_r.shift[7] & ~sdaS)
        begin
          s_nxt.arbLost = 1'b1;
          s_nxt.master = 1'b0;
          s_nxt.trc = 1'b0;
          s_nxt.mstSclLow = 1'b0;
        end
      end
      if (s_r.bitCnt == ISES_BIT_LAST)
        s_nxt.ackDet = ~sdaS;
      // byte complete on the 8th rise
      if (s_r.bitCnt == 4'(ISES_BIT_LAST - 4'h1))
      begin
        s_nxt.ackDrive = 1'b0;
        if (s_r.phase == ISES_PH_ADDR)
        begin
          if (s_r.master & ~(s_r.shift[7] & ~sdaS))
            s_nxt.trc = ~sdaS;
          else
          begin
            s_nxt.addrMatch = matchNow;
            s_nxt.extCode = extNow;
            s_nxt.ackDrive = matchNow | extNow;
            s_nxt.trc = (matchNow | extNow) & sdaS;
          end
        end
        else if (s_r.phase == ISES_PH_DATA)
        begin
          s_nxt.rxData = byteNow;
          s_nxt.ackDrive = ~s_r.trc & s_r.ctrl[ISES_CB_ACKE];
        end
      end
    end

    // events on falling edges
    if (sclFall & s_r.busy)
    begin
      if (s_r.bitCnt == ISES_BIT_LAST & s_r.phase == ISES_PH_DATA
          & ~s_r.ctrl[ISES_CB_WTIM])
      begin
        ev[ISES_EV_DATA] = 1'b1;
        s_nxt.hold = 1'b1;
      end
      if (s_r.bitCnt == ISES_BIT_ACK)
      begin
        s_nxt.bitCnt = '0;
        s_nxt.ackDrive = 1'b0;
        if (s_r.trc)
          s_nxt.shift = s_r.txByte;
        if (s_r.phase == ISES_PH_ADDR)
        begin
          // address events always on the 9th edge
          if (s_r.master | s_r.addrMatch | s_r.extCode)
          begin
            s_nxt.phase = ISES_PH_DATA;
            s_nxt.hold = 1'b1;
            ev[ISES_EV_ADDR] = 1'b1;
            ev[ISES_EV_EXT] = s_r.extCode;
            ev[ISES_EV_ARB] = s_r.arbLost;
          end
          else
          begin
            s_nxt.phase = ISES_PH_DROP;
            ev[ISES_EV_ARB] = s_r.arbLost;
          end
        end
        else if (s_r.phase == ISES_PH_DATA)
        begin
          if (s_r.trc & ~s_r.ackDet & ~s_r.master)
          begin
            ev[ISES_EV_DATA] = 1'b1;
            s_nxt.phase = ISES_PH_DROP;
            s_nxt.trc = 1'b0;
          end
          else if (s_r.ctrl[ISES_CB_WTIM])
          begin
            ev[ISES_EV_DATA] = 1'b1;
            s_nxt.hold = 1'b1;
          end
        end
      end
    end

    // start condition, including a repeated start
    if (startSeen)
    begin
      s_nxt.busy = 1'b1;
      s_nxt.bitCnt = '0;
      s_nxt.phase = ISES_PH_ADDR;
      s_nxt.startDet = 1'b1;
      s_nxt.stopDet = 1'b0;
      s_nxt.addrMatch = 1'b0;
      s_nxt.extCode = 1'b0;
      s_nxt.ackDrive = 1'b0;
      s_nxt.hold = 1'b0;
      s_nxt.arbLost = 1'b0;
      s_nxt.trc = 1'b0;
      if (s_r.mstGen)
      begin
        s_nxt.master = 1'b1;
        s_nxt.trc = 1'b1;
        s_nxt.mstGen = 1'b0;
        s_nxt.mstPend = 1'b0;
        s_nxt.mstCnt = '0;
      end
      else if (s_r.master & s_r.bitCnt != '0)
      begin
        s_nxt.master = 1'b0;
        s_nxt.arbLost = 1'b1;
        s_nxt.mstSclLow = 1'b0;
        ev[ISES_EV_ARB] = 1'b1;
      end
    end

    // stop condition ends everything
    if (stopSeen)
    begin
      s_nxt.busy = 1'b0;
      s_nxt.phase = ISES_PH_IDLE;
      s_nxt.master = 1'b0;
      s_nxt.mstSclLow = 1'b0;
      s_nxt.hold = 1'b0;
      s_nxt.trc = 1'b0;
      s_nxt.ackDrive = 1'b0;
      s_nxt.addrMatch = 1'b0;
      s_nxt.extCode = 1'b0;
      s_nxt.arbLost = 1'b0;
      s_nxt.startDet = 1'b0;
      s_nxt.stopDet = 1'b1;
      ev[ISES_EV_STOP] = s_r.ctrl[ISES_CB_SPIE];
    end

    // master clock generation while not waiting
    if (s_r.master & ~s_r.hold)
    begin
      s_nxt.mstCnt = 10'(s_r.mstCnt + 10'h001);
      if (s_r.mstCnt == ISES_HALF_MAX)
      begin
        s_nxt.mstCnt = '0;
        if (s_r.mstSclLow)
          s_nxt.mstSclLow = 1'b0;
        else if (sclS)
          s_nxt.mstSclLow = 1'b1;
      end
    end

    // data line drive changes only while the clock is low, except the start pull-down and the release when disabled
    txBit = s_r.trc & (s_r.bitCnt < ISES_BIT_LAST) & ~s_r.shift[7]
            & (s_r.phase == ISES_PH_DATA | (s_r.phase == ISES_PH_ADDR & s_r.master));
    if (s_r.mstGen)
      s_nxt.sdaRel = 1'b0;
    else if (~sclS)
      s_nxt.sdaRel = ~(txBit | s_r.ackDrive);
    if (~s_r.ctrl[ISES_CB_EN])
    begin
      s_nxt.sdaRel = 1'b1;
      s_nxt.hold = 1'b0;
      s_nxt.mstSclLow = 1'b0;
      s_nxt.mstGen = 1'b0;
    end

    // snapshot captured on every event
    if (ev != '0)
    begin
      s_nxt.snap[ISES_SB_MST] = s_nxt.master;
      s_nxt.snap[ISES_SB_ARB] = s_nxt.arbLost;
      s_nxt.snap[ISES_SB_EXT] = s_nxt.extCode;
      s_nxt.snap[ISES_SB_MATCH] = s_nxt.addrMatch;
      s_nxt.snap[ISES_SB_TRC] = s_nxt.trc;
      s_nxt.snap[ISES_SB_ACK] = s_nxt.ackDet;
      s_nxt.snap[ISES_SB_STD] = s_nxt.startDet;
      s_nxt.snap[ISES_SB_SPD] = s_nxt.stopDet;
    end

    // clock pin drive kept in its own flop so the pin comes straight from it
    s_nxt.sclRel = ~(s_nxt.hold | s_nxt.mstSclLow);
    // sticky status: read clears only what was returned, a new event wins
    s_nxt.irqStat = ((rd & sel[4]) ? (s_r.irqStat & ~s_r.rdata[ISES_EVW-1:0]) : s_r.irqStat) | ev;
    s_nxt.irq = |(s_nxt.irqStat & s_nxt.irqMask);
  end

  // state register
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r <= '0;
      s_r.phase <= ISES_PH_IDLE;
      s_r.sclP <= 1'b1;
      s_r.sdaP <= 1'b1;
      s_r.sclRel <= 1'b1;
      s_r.sdaRel <= 1'b1;
      s_r.ctrl <= ISES_CTRL_RST;
      s_r.ownAddr <= ISES_ADDR_RST;
      s_r.irqMask <= ISES_MASK_RST;
    end
    else
      s_r <= s_nxt;
  end

  // outputs straight from flops; sclOut and sdaOut tied low
  assign prdata = s_r.rdata;
  assign pready = s_r.ready;
  assign pslverr = s_r.err;
  assign sclOut = 1'b0;
  assign sdaOut = 1'b0;
  assign sclOe_n = s_r.sclRel;
  assign sdaOe_n = s_r.sdaRel;
  assign transmitDirection = s_r.trc;
  assign busEventIrq = s_r.irq;
endmodule

// *** rtl/ises_sync.sv ***
// ises_sync: two-flop synchronisers for the bus clock and data pins
// assumes pin levels are asynchronous to core_clk
`timescale 1ns/1ns
module ises_sync (
  input wire logic core_clk, // core clock
  input wire logic rst_n, // async reset, active low
  input wire logic sclIn, // raw clock pin
  input wire logic sdaIn, // raw data pin
  output logic sclSync, // synchronised clock level
  output logic sdaSync // synchronised data level
);
  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] sync;
  } ises_sync_t;
  ises_sync_t s_r;
  ises_sync_t s_nxt;
  // first stage feeds only the second stage
  always_comb
  begin
    s_nxt.meta = {sclIn, sdaIn};
    s_nxt.sync = s_r.meta;
  end
  // released bus reads high
  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      s_r <= '1;
    else
      s_r <= s_nxt;
  end
  assign sclSync = s_r.sync[1];
  assign sdaSync = s_r.sync[0];
endmodule

// *** shared/ises_pkg.sv ***
// ises_pkg: constants and types for the two-wire slave event sequencer
// assumes a 250 MHz core clock and a 32-bit APB register port
package ises_pkg;
  // register byte offsets
  localparam logic [7:0] ISES_OFS_CTRL = 8'h00;
  localparam logic [7:0] ISES_OFS_ADDR = 8'h04;
  localparam logic [7:0] ISES_OFS_DATA = 8'h08;
  localparam logic [7:0] ISES_OFS_SNAP = 8'h0c;
  localparam logic [7:0] ISES_OFS_ISTAT = 8'h10;
  localparam logic [7:0] ISES_OFS_IMASK = 8'h14;
  // control register fields
  localparam int ISES_CB_EN = 0;
  localparam int ISES_CB_WTIM = 1;
  localparam int ISES_CB_SPIE = 2;
  localparam int ISES_CB_ACKE = 3;
  localparam int ISES_CB_LEAVE = 4;
  localparam int ISES_CB_WREL = 5;
  localparam int ISES_CB_START = 6;
  // snapshot fields
  localparam int ISES_SB_MST = 7;
  localparam int ISES_SB_ARB = 6;
  localparam int ISES_SB_EXT = 5;
  localparam int ISES_SB_MATCH = 4;
  localparam int ISES_SB_TRC = 3;
  localparam int ISES_SB_ACK = 2;
  localparam int ISES_SB_STD = 1;
  localparam int ISES_SB_SPD = 0;
  // event status / mask fields
  localparam int ISES_EV_ADDR = 0;
  localparam int ISES_EV_DATA = 1;
  localparam int ISES_EV_STOP = 2;
  localparam int ISES_EV_ARB = 3;
  localparam int ISES_EV_EXT = 4;
  localparam int ISES_EVW = 5;
  // reset values
  localparam logic [3:0] ISES_CTRL_RST = 4'h0;
  localparam logic [6:0] ISES_ADDR_RST = 7'h00;
  localparam logic [ISES_EVW-1:0] ISES_MASK_RST = 5'h00;
  // bus bit counting and extension code prefix
  localparam logic [3:0] ISES_BIT_LAST = 4'h8;
  localparam logic [3:0] ISES_BIT_ACK = 4'h9;
  localparam logic [3:0] ISES_EXT_PREFIX = 4'h0;
  // master clock half period
  localparam int ISES_CLK_NS = 4;
  localparam int ISES_HALF_NS = 2500;
  localparam int ISES_HALF_CYC = ISES_HALF_NS / ISES_CLK_NS;
  localparam logic [9:0] ISES_HALF_MAX = 10'(ISES_HALF_CYC - 1);
  // byte phase of the slave sequencer
  typedef enum logic [3:0] {
    ISES_PH_IDLE = 4'b0001,
    ISES_PH_ADDR = 4'b0010,
    ISES_PH_DATA = 4'b0100,
    ISES_PH_DROP = 4'b1000
  } ises_phase_t;
endpackage

// *** verification/i2c_slave_event_sequencing_bench.sv ***
// i2c_slave_event_sequencing_bench: self-checking bench for ises_core
// assumes ises_bus_master on the wires and the monitor bound to the core
`timescale 1ns/1ns
module i2c_slave_event_sequencing_bench;
  import ises_pkg::*;
  localparam logic [31:0] EV_A = 32'h1 << ISES_EV_ADDR;
  localparam logic [31:0] EV_D = 32'h1 << ISES_EV_DATA;
  localparam logic [31:0] EV_S = 32'h1 << ISES_EV_STOP;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, sclOut, sclOe_n, sdaOut, sdaOe_n, transmitDirection, busEventIrq;
  logic mScl, mSda, sclW, sdaW, e, a;
  logic [31:0] seed = 32'hd4d5c1dd;
  logic [31:0] r, cfg;
  logic [7:0] v;
  logic [6:0] own;
  logic [7:0] q[$];
  int n_fail = 0;
  int n_tests = 0;
  // open-drain wires: any party pulls low; 1 ns skew keeps pin changes off the clock edge
  assign #1 sclW = mScl & (sclOe_n | sclOut);
  assign #1 sdaW = mSda & (sdaOe_n | sdaOut);
  // 250 MHz core clock
  always #2 core_clk = ~core_clk;
  ises_core dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sclIn(sclW), .sclOut(sclOut), .sclOe_n(sclOe_n), .sdaIn(sdaW), .sdaOut(sdaOut),
    .sdaOe_n(sdaOe_n), .transmitDirection(transmitDirection), .busEventIrq(busEventIrq)
  );
  ises_bus_master mst_u (.sclLine(sclW), .sdaLine(sdaW), .sclDrv(mScl), .sdaDrv(mSda));
  // next pseudo-random byte
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction
  // compare one result with the model
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one apb transfer, answer left in r and e
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    int k;
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= ad;
    pwdata <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge core_clk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50)
      n_fail++;
  endtask
  task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
    apb(1'b1, ad, wd);
  endtask
  task automatic rc(input logic [7:0] ad, input logic [31:0] x);
    apb(1'b0, ad, 32'h0);
    chk(r, x);
  endtask
  // bounded wait for the interrupt line
  task automatic waitIrq();
    int k;
    k = 0;
    while (busEventIrq !== 1'b1 && k < 300)
    begin
      @(posedge core_clk);
      k++;
    end
    chk(32'(busEventIrq), 32'h1);
    apb(1'b0, ISES_OFS_SNAP, 32'h0);
    chk(32'(r[ISES_SB_MST]), 32'h0);
  endtask
  // start, address byte, ack and the address event
  task automatic addrPhase(input logic [7:0] ab);
    mst_u.start();
    mst_u.putByte(ab);
    mst_u.getBit(a);
    chk(32'(a), 32'h0);
    waitIrq();
    rc(ISES_OFS_ISTAT, EV_A);
  endtask
  // one byte to the core; early means the event comes before the ack bit
  task automatic rxByte(input logic ackExp, input logic early);
    v = rnd();
    q.push_back(v);
    mst_u.putByte(v);
    if (!early)
    begin
      mst_u.getBit(a);
      chk(32'(a), 32'(ackExp));
    end
    waitIrq();
    chk(32'(sclOe_n), 32'h0);
    rc(ISES_OFS_ISTAT, EV_D);
    rc(ISES_OFS_DATA, {24'h0, q.pop_front()});
    wr(ISES_OFS_CTRL, cfg | 32'h20);
    if (early)
    begin
      mst_u.getBit(a);
      chk(32'(a), 32'(ackExp));
    end
  endtask
  task automatic stopPhase(input logic [31:0] ev);
    mst_u.stop();
    waitIrq();
    rc(ISES_OFS_ISTAT, ev);
  endtask
  task automatic end_sim();
    $display("comparisons=%0d mismatches=%0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // cut a hang short
  initial
  begin
    #100000;
    n_fail++;
    end_sim();
  end
  // main sequence
  initial
  begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    rc(ISES_OFS_CTRL, 32'h0);
    rc(ISES_OFS_IMASK, 32'h0);
    rc(8'h18, 32'h0);
    chk(32'(e), 32'h1);
    v = rnd();
    own = {1'b1, v[5:0]};
    wr(ISES_OFS_ADDR, {25'h0, own});
    rc(ISES_OFS_ADDR, {25'h0, own});
    // extension code with all events masked, stop interrupt off
    wr(ISES_OFS_CTRL, 32'h0b);
    v = rnd();
    mst_u.start();
    mst_u.putByte({4'h0, v[2:0], 1'b0});
    mst_u.getBit(a);
    chk(32'(a), 32'h0);
    repeat (20) @(posedge core_clk);
    chk(32'(busEventIrq), 32'h0);
    wr(ISES_OFS_IMASK, 32'h1f);
    repeat (3) @(posedge core_clk);
    chk(32'(busEventIrq), 32'h1);
    wr(ISES_OFS_IMASK, 32'h0);
    wr(ISES_OFS_IMASK, 32'h1f);
    apb(1'b0, ISES_OFS_ISTAT, 32'h0);
    chk(32'(r[ISES_EV_EXT]), 32'h1);
    apb(1'b0, ISES_OFS_SNAP, 32'h0);
    chk(32'(r[ISES_SB_EXT]), 32'h1);
    repeat (3) @(posedge core_clk);
    chk(32'(busEventIrq), 32'h0);
    wr(ISES_OFS_CTRL, 32'h1b);
    mst_u.stop();
    repeat (20) @(posedge core_clk);
    rc(ISES_OFS_ISTAT, 32'h0);
    // slave receive, events on the ninth fall
    cfg = 32'h0f;
    wr(ISES_OFS_CTRL, cfg);
    addrPhase({own, 1'b0});
    chk(32'(sclOe_n), 32'h0);
    rc(ISES_OFS_SNAP, 32'h16);
    wr(ISES_OFS_CTRL, cfg | 32'h20);
    rxByte(1'b0, 1'b0);
    rxByte(1'b0, 1'b0);
    cfg = 32'h07;
    wr(ISES_OFS_CTRL, cfg);
    rxByte(1'b1, 1'b0);
    stopPhase(EV_S);
    rc(ISES_OFS_SNAP, 32'h01);
    // data events on the eighth fall
    cfg = 32'h0d;
    wr(ISES_OFS_CTRL, cfg);
    addrPhase({own, 1'b0});
    wr(ISES_OFS_CTRL, cfg | 32'h20);
    rxByte(1'b0, 1'b1);
    stopPhase(EV_S);
    // slave transmit until the master withholds ack
    cfg = 32'h0f;
    wr(ISES_OFS_CTRL, cfg);
    addrPhase({own, 1'b1});
    chk(32'(transmitDirection), 32'h1);
    apb(1'b0, ISES_OFS_SNAP, 32'h0);
    chk(32'(r[ISES_SB_TRC]), 32'h1);
    for (int i = 0; i < 2; i++)
    begin
      q.push_back(rnd());
      wr(ISES_OFS_DATA, {24'h0, q[0]});
      mst_u.getByte(v, i[0]);
      chk({24'h0, v}, {24'h0, q.pop_front()});
      waitIrq();
      rc(ISES_OFS_ISTAT, EV_D);
    end
    chk(32'(transmitDirection), 32'h0);
    chk(32'(sclOe_n), 32'h1);
    stopPhase(EV_S);
    // foreign address: no ack, no event, no hold
    mst_u.start();
    mst_u.putByte({own ^ 7'h01, 1'b0});
    mst_u.getBit(a);
    chk(32'(a), 32'h1);
    repeat (20) @(posedge core_clk);
    chk(32'(busEventIrq), 32'h0);
    stopPhase(EV_S);
    chk(32'(mst_u.stuck), 32'h0);
    end_sim();
  end
endmodule

// *** verification/ises_bus_master.sv ***
// ises_bus_master: behavioural two-wire bus master facing the core
// assumes open-drain wires with pull-ups resolved by the bench; 48 ns bit time
`timescale 1ns/1ns
module ises_bus_master (
  input wire logic sclLine, // resolved clock wire
  input wire logic sdaLine, // resolved data wire
  output logic sclDrv, // low pulls clock down
  output logic sdaDrv // low pulls data down
);
  int stuck = 0;
  // bus released, clock stands still between frames
  initial
  begin
    sclDrv = 1'b1;
    sdaDrv = 1'b1;
  end
  // raise the clock, wait out a slave hold, keep the high half
  task automatic rise();
    int k;
    sclDrv = 1'b1;
    #4;
    k = 0;
    while (sclLine !== 1'b1 && k < 2000)
    begin
      #4;
      k++;
    end
    if (k >= 2000)
      stuck++;
    #20;
  endtask
  // one bit out, data changed only while clock low
  task automatic putBit(input logic b);
    sdaDrv = b;
    #12;
    rise();
    sclDrv = 1'b0;
    #12;
  endtask
  // one bit in, sampled at the end of the high half
  task automatic getBit(output logic b);
    sdaDrv = 1'b1;
    #12;
    rise();
    b = sdaLine;
    sclDrv = 1'b0;
    #12;
  endtask
  // start or repeated start: data falls while clock high
  task automatic start();
    sdaDrv = 1'b1;
    #12;
    rise();
    sdaDrv = 1'b0;
    #24;
    sclDrv = 1'b0;
    #12;
  endtask
  // stop: data rises while clock high, ends the exchange
  task automatic stop();
    sdaDrv = 1'b0;
    #12;
    rise();
    sdaDrv = 1'b1;
    #48;
  endtask
  // msb first byte out
  task automatic putByte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--)
      putBit(b[i]);
  endtask
  // byte in, then ack (0) or no ack (1)
  task automatic getByte(output logic [7:0] b, input logic nack);
    logic t;
    for (int i = 7; i >= 0; i--)
    begin
      getBit(t);
      b[i] = t;
    end
    putBit(nack);
  endtask
endmodule

// *** verification/ises_core_monitor.sv ***
// ises_core_monitor: concurrent checks on the ports of ises_core
// assumes one core_clk domain, rst_n active low, open-drain pins resolved outside
`timescale 1ns/1ns
module ises_core_monitor (
  input wire logic core_clk, // core clock
  input wire logic rst_n, // async reset
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb address
  input wire logic [31:0] pwdata, // apb write data
  input wire logic [31:0] prdata, // apb read data
  input wire logic pready, // apb ready
  input wire logic pslverr, // apb error
  input wire logic sclIn, // clock wire
  input wire logic sclOut, // clock drive value
  input wire logic sclOe_n, // clock enable
  input wire logic sdaIn, // data wire
  input wire logic sdaOut, // data drive value
  input wire logic sdaOe_n, // data enable
  input wire logic transmitDirection, // direction
  input wire logic busEventIrq // interrupt
);
  import ises_pkg::*;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  logic wrDone;
  // a write completing at this edge
  assign wrDone = psel && penable && pready && pwrite;
  // apb timing and error answers
  chk_ready_wait: assert property ($rose(psel && penable) |-> !pready ##1 pready)
    else $error("ready not in second access cycle");
  chk_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  chk_err_unmapped: assert property (pready && paddr > ISES_OFS_IMASK |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_err_mapped: assert property (pready && paddr <= ISES_OFS_IMASK && paddr[1:0] == 2'h0 |-> !pslverr)
    else $error("mapped access refused");
  chk_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  // clock hold and its release, interrupt masking and data drive timing
  chk_hold_stands: assert property (!sclOe_n && !wrDone |=> !sclOe_n)
    else $error("clock hold dropped without release");
  chk_release_fast: assert property (wrDone && paddr == ISES_OFS_CTRL && pwdata[ISES_CB_WREL]
    |-> ##[1:3] sclOe_n)
    else $error("clock hold not released");
  chk_mask_quiet: assert property (wrDone && paddr == ISES_OFS_IMASK && pwdata[4:0] == 5'h0
    |-> ##[1:2] !busEventIrq)
    else $error("interrupt high with all events masked");
  chk_sda_scl_low: assert property ($changed(sdaOe_n) |-> !sclIn && sdaOut == 1'b0)
    else $error("data drive changed while clock high");
  // main scenarios seen
  cov_hold: cover property ($fell(sclOe_n));
  cov_tx: cover property ($rose(transmitDirection));
  cov_err: cover property (pready && pslverr);
endmodule

bind ises_core ises_core_monitor mon_u (
  .core_clk(core_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .sclIn(sclIn), .sclOut(sclOut), .sclOe_n(sclOe_n), .sdaIn(sdaIn), .sdaOut(sdaOut),
  .sdaOe_n(sdaOe_n), .transmitDirection(transmitDirection), .busEventIrq(busEventIrq)
);
